// File: rtl/lane_test_pkg.sv
// constants for the multi-lane serial test-pattern generator
// assumes one core clock that runs one parallel octet per lane per cycle
package lane_test_pkg;
  localparam int LANES_PER_LINK = 8;
  localparam int LANES          = 16;
  localparam int LFSR_W         = 31;
  localparam int BUF_DEPTH      = 2;
  localparam int STEP_BITS      = 8;

  // test-select codes
  localparam logic [3:0] SEL_OFF    = 4'h0;
  localparam logic [3:0] SEL_PRBS7  = 4'h1;
  localparam logic [3:0] SEL_PRBS9  = 4'h2;
  localparam logic [3:0] SEL_PRBS15 = 4'h3;
  localparam logic [3:0] SEL_PRBS23 = 4'h4;
  localparam logic [3:0] SEL_PRBS31 = 4'h5;
  localparam logic [3:0] SEL_CLOCK  = 4'h6;
  localparam logic [3:0] SEL_RAMP   = 4'h7;
  localparam logic [3:0] SEL_SHORT  = 4'h8;

  // N' codes of the link mode
  localparam logic [1:0] NP_8  = 2'h0;
  localparam logic [1:0] NP_12 = 2'h1;
  localparam logic [1:0] NP_16 = 2'h2;

  // feedback taps, as distance back in the bit stream
  localparam int TAP7_A  = 6;
  localparam int TAP7_B  = 7;
  localparam int TAP9_A  = 5;
  localparam int TAP9_B  = 9;
  localparam int TAP15_A = 14;
  localparam int TAP15_B = 15;
  localparam int TAP23_A = 18;
  localparam int TAP23_B = 23;
  localparam int TAP31_A = 28;
  localparam int TAP31_B = 31;

  localparam logic [7:0] CLK_HIGH   = 8'hff;
  localparam logic [7:0] CLK_LOW    = 8'h00;
  localparam logic [7:0] SHORT_TOP  = 8'hff;
  localparam logic [3:0] NIB_TOP    = 4'hf;
  localparam logic [3:0] TAIL_NIB   = 4'h0;
  localparam logic [3:0] NIB_LAST   = 4'hf;
  localparam logic [4:0] OCT_RESET  = 5'h00;
  localparam logic [9:0] FRM_RESET  = 10'h000;
endpackage

// File: rtl/serial_lane_test_pattern_gen.sv
// test-pattern source for the sixteen serial lanes (links a and b)
// assumes the link layer and serializers sit downstream and honour the
// bypass flags that travel with each word
//
// Overview of operation
// [RULE_01] select pattern; lane power follows link mode
// [RULE_02] host changes select only with link disabled
// [RULE_03] prbs skips transport and link layers
// [RULE_04] prbs7: bit n = n-6 xor n-7
// [RULE_05] prbs9 taps 5,9; prbs15 taps 14,15
// [RULE_06] prbs23 taps 18,23; prbs31 taps 28,31
// [RULE_07] every lane seeds prbs differently
// [RULE_08] clock mode: eight ones, eight zeros, repeating
// [RULE_09] ramp replaces formatter data, link layer runs
// [RULE_10] ramp waits for ilas end or serdes ready
// [RULE_11] ramp identical on every lane
// [RULE_12] k up to 256: ramp 0 to k-1
// [RULE_13] k above 256: ramp wraps at 0xff
// [RULE_14] transport patterns ignore link coding
// [RULE_15] n' 8 or 12 uses short pattern
// [RULE_16] only enabled low lanes carry pattern
// [RULE_17] n' 8: frame0 i, frame1 0xff-i
// [RULE_18] n' 12 f8: five words 15-i,i,1..5
// [RULE_19] n' 12 f2 s8: nibble count over six lanes
// [RULE_20] n' 12 f2 s4: nibble count over three lanes
// [RULE_21] both links send the same pattern
// [RULE_22] n' 16 needs long pattern, not short; with short selected this block sends no words at all for n' 16
// [RULE_23] advance per word; restart on change
module serial_lane_test_pattern_gen (
  input  wire logic         core_clk,
  input  wire logic         nrst,
  input  wire logic [3:0]   test_pattern_select,
  input  wire logic [3:0]   link_mode_lanes,
  input  wire logic [1:0]   link_mode_nprime,
  input  wire logic [4:0]   frame_octets,
  input  wire logic [9:0]   multiframe_frames,
  input  wire logic         coding_64b66b,
  input  wire logic         link_enable,
  input  wire logic         ilas_done,
  input  wire logic         serdes_ready,
  output logic [15:0]       lane_power,
  output logic              test_active,
  output logic [127:0]      out_data,
  output logic              out_bypass_link,
  output logic              out_bypass_transport,
  output logic              out_valid,
  input  wire logic         out_ready
);

  ////////////////////////////////////////////////////////////////////////
  // mode decode

  function automatic logic is_prbs(input logic [3:0] s);
    return (s >= lane_test_pkg::SEL_PRBS7) &&
           (s <= lane_test_pkg::SEL_PRBS31);
  endfunction

  logic [3:0] sel_q;
  logic       en_q;
  logic       restart;
  logic       mode_prbs;
  logic       mode_clock;
  logic       mode_ramp;
  logic       mode_short;
  logic       ramp_go;
  logic       gen_valid;
  logic       buf_in_ready;
  logic       fire;

  assign mode_prbs  = is_prbs(test_pattern_select);
  assign mode_clock = test_pattern_select == lane_test_pkg::SEL_CLOCK;
  assign mode_ramp  = test_pattern_select == lane_test_pkg::SEL_RAMP;
  // n' 16 modes need the long pattern, which this block does not make
  assign mode_short = (test_pattern_select == lane_test_pkg::SEL_SHORT) &&
                      (link_mode_nprime != lane_test_pkg::NP_16); // [RULE_22]
  // ramp waits for the link layer to reach its data phase
  assign ramp_go    = coding_64b66b ? serdes_ready : ilas_done; // [RULE_10]
  assign test_active = test_pattern_select != lane_test_pkg::SEL_OFF;

  // select change or link re-enable throws away all generator state
  assign restart = (test_pattern_select != sel_q) ||
                   (link_enable && !en_q); // [RULE_23]

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      sel_q <= lane_test_pkg::SEL_OFF;
      en_q  <= 1'b0;
    end else begin
      sel_q <= test_pattern_select;
      en_q  <= link_enable;
    end
  end

  assign gen_valid = link_enable && !restart &&
                     (mode_prbs || mode_clock || mode_short ||
                      (mode_ramp && ramp_go)); // [RULE_01]
  assign fire = gen_valid && buf_in_ready; // [RULE_23]

  ////////////////////////////////////////////////////////////////////////
  // lane power: link mode alone decides, whatever the test

  genvar gl;
  generate
    for (gl = 0; gl < lane_test_pkg::LANES; gl++) begin : g_pwr
      assign lane_power[gl] =
        4'(gl % lane_test_pkg::LANES_PER_LINK) < link_mode_lanes; // [RULE_01]
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////
  // frame and multiframe position

  logic [4:0] oct_pos;
  logic [9:0] frm_pos;
  logic       frm_par;
  logic       clk_phase;
  logic       frame_end;

  assign frame_end = oct_pos == (frame_octets - 5'h01);

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      oct_pos <= lane_test_pkg::OCT_RESET;
      frm_pos <= lane_test_pkg::FRM_RESET;
      frm_par <= 1'b0;
    end else if (restart) begin
      oct_pos <= lane_test_pkg::OCT_RESET;
      frm_pos <= lane_test_pkg::FRM_RESET;
      frm_par <= 1'b0;
    end else if (fire) begin
      if (frame_end) begin
        oct_pos <= lane_test_pkg::OCT_RESET;
        frm_par <= !frm_par;
        if (frm_pos == (multiframe_frames - 10'h001))
          frm_pos <= lane_test_pkg::FRM_RESET;
        else
          frm_pos <= frm_pos + 10'h001;
      end else begin
        oct_pos <= oct_pos + 5'h01;
      end
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst)
      clk_phase <= 1'b0;
    else if (restart)
      clk_phase <= 1'b0;
    else if (fire && mode_clock)
      clk_phase <= !clk_phase; // [RULE_08]
  end

  ////////////////////////////////////////////////////////////////////////
  // pattern functions

  // eight serial bits per call; bit 7 of the result leaves first
  function automatic logic [30:0] prbs_step(input logic [30:0] s,
                                            input logic [3:0]  m);
    logic [30:0] t;
    int          a;
    int          b;
    t = s;
    unique case (m)
      lane_test_pkg::SEL_PRBS7:  begin
        a = lane_test_pkg::TAP7_A;  b = lane_test_pkg::TAP7_B;  // [RULE_04]
      end
      lane_test_pkg::SEL_PRBS9:  begin
        a = lane_test_pkg::TAP9_A;  b = lane_test_pkg::TAP9_B;  // [RULE_05]
      end
      lane_test_pkg::SEL_PRBS15: begin
        a = lane_test_pkg::TAP15_A; b = lane_test_pkg::TAP15_B; // [RULE_05]
      end
      lane_test_pkg::SEL_PRBS23: begin
        a = lane_test_pkg::TAP23_A; b = lane_test_pkg::TAP23_B; // [RULE_06]
      end
      default: begin
        a = lane_test_pkg::TAP31_A; b = lane_test_pkg::TAP31_B; // [RULE_06]
      end
    endcase
    for (int i = 0; i < lane_test_pkg::STEP_BITS; i++)
      t = {t[29:0], t[a-1] ^ t[b-1]};
    return t;
  endfunction

  function automatic logic [3:0] short_nib(input logic       f8,
                                           input logic [2:0] idx,
                                           input logic [3:0] j);
    int w;
    int p;
    w = int'(j) / 3;
    p = int'(j) % 3;
    if (!f8)
      return 4'(4 * int'(idx) + int'(j)); // [RULE_19] [RULE_20]
    if (j == lane_test_pkg::NIB_LAST)
      return lane_test_pkg::TAIL_NIB;
    if (p == 0)
      return lane_test_pkg::NIB_TOP - {1'b0, idx}; // [RULE_18]
    if (p == 1)
      return {1'b0, idx};
    return 4'(w + 1);
  endfunction

  // coding is not an input here: both link codings see the same octets
  // [RULE_14]
  function automatic logic [7:0] short_octet(input logic [1:0] np,
                                             input logic       f8,
                                             input logic [2:0] idx,
                                             input logic       par,
                                             input logic [2:0] k);
    logic [3:0] j;
    j = {k, 1'b0};
    if (np == lane_test_pkg::NP_8)
      return par ? lane_test_pkg::SHORT_TOP - {5'h00, idx}
                 : {5'h00, idx}; // [RULE_17]
    return {short_nib(f8, idx, j), short_nib(f8, idx, j | 4'h1)};
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // per-lane generators

  // unpacked so that each lane's process owns its own element
  logic [7:0]       gen_word [lane_test_pkg::LANES];
  logic [30:0]      lfsr     [lane_test_pkg::LANES];
  wire  [127:0]     gen_flat;
  logic             f8;
  logic [2:0]       oct_k;

  assign f8    = frame_octets == 5'h08;
  assign oct_k = f8 ? oct_pos[2:0] : {2'b00, oct_pos[0]};

  generate
    for (gl = 0; gl < lane_test_pkg::LANES; gl++) begin : g_lane
      localparam logic [2:0] IDX = 3'(gl % lane_test_pkg::LANES_PER_LINK);
      // distinct nonzero seed per lane; fits even the 7-bit register
      localparam logic [30:0] SEED = 31'(gl + 1); // [RULE_07]
      logic [30:0] lfsr_next;

      assign lfsr_next = prbs_step(lfsr[gl], test_pattern_select);
      assign gen_flat[8*gl+:8] = gen_word[gl];

      always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst)
          lfsr[gl] <= SEED;
        else if (restart)
          lfsr[gl] <= SEED; // [RULE_07]
        else if (fire && mode_prbs)
          lfsr[gl] <= lfsr_next; // [RULE_03]
      end

      always_comb begin
        gen_word[gl] = 8'h00;
        if (mode_prbs)
          gen_word[gl] = lfsr_next[7:0];
        else if (mode_clock)
          gen_word[gl] = clk_phase ? lane_test_pkg::CLK_LOW
                                   : lane_test_pkg::CLK_HIGH; // [RULE_08]
        else if (mode_ramp)
          // one value per frame; wraps past 0xff for long multiframes
          gen_word[gl] = frm_pos[7:0]; // [RULE_11] [RULE_12] [RULE_13]
        else if (mode_short && IDX < link_mode_lanes) // [RULE_16]
          gen_word[gl] = short_octet(link_mode_nprime, f8, IDX,
                                     frm_par, oct_k); // [RULE_15] [RULE_21]
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////
  // two-entry buffer; a stalled receiver freezes the generators

  logic [129:0] buf_mem [lane_test_pkg::BUF_DEPTH];
  logic [1:0]   buf_cnt;
  logic         wr_ptr;
  logic         rd_ptr;
  logic         push;
  logic         pop;
  logic [129:0] buf_in;

  // prbs and clock skip both layers; ramp only the transport layer
  assign buf_in = {mode_prbs || mode_clock,
                   mode_prbs || mode_clock || mode_ramp,
                   gen_flat}; // [RULE_03] [RULE_09]
  assign buf_in_ready = buf_cnt != 2'(lane_test_pkg::BUF_DEPTH);
  assign push = fire;
  assign pop  = out_valid && out_ready;
  assign out_valid = buf_cnt != 2'h0;

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      buf_cnt <= 2'h0;
      wr_ptr  <= 1'b0;
      rd_ptr  <= 1'b0;
    end else if (restart) begin
      buf_cnt <= 2'h0;
      wr_ptr  <= 1'b0;
      rd_ptr  <= 1'b0;
    end else begin
      if (push)
        wr_ptr <= !wr_ptr;
      if (pop)
        rd_ptr <= !rd_ptr;
      buf_cnt <= buf_cnt + 2'(push) - 2'(pop);
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      buf_mem[0] <= 130'h0;
      buf_mem[1] <= 130'h0;
    end else if (push) begin
      buf_mem[wr_ptr] <= buf_in;
    end
  end

  assign out_data             = buf_mem[rd_ptr][127:0];
  assign out_bypass_transport = buf_mem[rd_ptr][128];
  assign out_bypass_link      = buf_mem[rd_ptr][129];

  ////////////////////////////////////////////////////////////////////////
  // assertions

  sequence s_fire_in(logic [3:0] m);
    fire && (test_pattern_select == m);
  endsequence

  sequence s_steady(logic [3:0] m);
    !restart && (test_pattern_select == m);
  endsequence

  a_power_mode: assert property (@(posedge core_clk) disable iff (!nrst)
    lane_power[8] == (link_mode_lanes != 4'h0)) // [RULE_01]
    else $error("lane power ignores link mode");

  a_prbs_bypass: assert property (@(posedge core_clk) disable iff (!nrst)
    s_fire_in(lane_test_pkg::SEL_PRBS7) ##1 (pop && buf_cnt == 2'h1)
    |-> out_bypass_link && out_bypass_transport) // [RULE_03]
    else $error("prbs word not marked as layer bypass");

  a_prbs7_recur: assert property (@(posedge core_clk) disable iff (!nrst)
    s_fire_in(lane_test_pkg::SEL_PRBS7) ##1 s_steady(lane_test_pkg::SEL_PRBS7)
    |-> lfsr[3][0] == (lfsr[3][6] ^ lfsr[3][7])) // [RULE_04]
    else $error("prbs7 recurrence broken");

  a_prbs9_recur: assert property (@(posedge core_clk) disable iff (!nrst)
    s_fire_in(lane_test_pkg::SEL_PRBS9) ##1 s_steady(lane_test_pkg::SEL_PRBS9)
    |-> lfsr[0][0] == (lfsr[0][5] ^ lfsr[0][9])) // [RULE_05]
    else $error("prbs9 recurrence broken");

  a_prbs31_recur: assert property (@(posedge core_clk) disable iff (!nrst)
    s_fire_in(lane_test_pkg::SEL_PRBS31) ##1
    s_steady(lane_test_pkg::SEL_PRBS31)
    |-> lfsr[9][0] == ($past(lfsr[9][20]) ^ $past(lfsr[9][23]))) // [RULE_06]
    else $error("prbs31 recurrence broken");

  a_clock_alt: assert property (@(posedge core_clk) disable iff (!nrst)
    s_fire_in(lane_test_pkg::SEL_CLOCK) ##1 s_fire_in(lane_test_pkg::SEL_CLOCK)
    |-> gen_word[5] == ~$past(gen_word[5])) // [RULE_08]
    else $error("clock pattern does not alternate");

  a_ramp_hold: assert property (@(posedge core_clk) disable iff (!nrst)
    mode_ramp && !ramp_go |-> !gen_valid) // [RULE_10]
    else $error("ramp started before link data phase");

  a_ramp_lanes: assert property (@(posedge core_clk) disable iff (!nrst) // [RULE_11]
    s_fire_in(lane_test_pkg::SEL_RAMP)
    |-> gen_word[0] == gen_word[15] && gen_word[0] == frm_pos[7:0])
    else $error("ramp lanes differ");

  a_short_n8: assert property (@(posedge core_clk) disable iff (!nrst)
    s_fire_in(lane_test_pkg::SEL_SHORT) &&
    link_mode_nprime == lane_test_pkg::NP_8 && link_mode_lanes > 4'h1
    |-> gen_word[9] == (frm_par ? 8'hfe : 8'h01)) // [RULE_17]
    else $error("short n8 octet wrong");

  a_unused_zero: assert property (@(posedge core_clk) disable iff (!nrst)
    s_fire_in(lane_test_pkg::SEL_SHORT) && link_mode_lanes < 4'h8
    |-> gen_word[7] == 8'h00 && gen_word[15] == 8'h00) // [RULE_16]
    else $error("disabled lane carries pattern");

  a_restart_zero: assert property (@(posedge core_clk) disable iff (!nrst) // [RULE_23]
    restart |=> oct_pos == 5'h00 && frm_pos == 10'h000 && !out_valid)
    else $error("restart left stale state");

endmodule

// File: verification/lane_rx_model.sv
// far-side receiver model for the lane test stream
// assumes the bench samples the stream on the same rising edges
module lane_rx_model (
  input  wire logic       core_clk,
  input  wire logic       out_valid,
  input  wire logic [1:0] stall_mode,
  output logic            out_ready,
  output logic            popped
);
  timeunit 1ns;
  timeprecision 1ns;
  ////////////////////////////////////////////////////////////////////////
  // ready moves only on the falling edge, so the pop edge sees it settled
  initial out_ready = 1'b1;
  always @(negedge core_clk) begin
    case (stall_mode)
      2'h0:    out_ready = 1'b1;
      2'h1:    out_ready = ($urandom_range(1, 0) == 1);
      default: out_ready = 1'b0;
    endcase
  end
  assign popped = out_valid && out_ready;
endmodule

// File: verification/serial_lane_test_pattern_gen_tb.sv
// self-checking bench for the lane test-pattern generator
// assumes the receiver model drives out_ready; expected words are queued
module serial_lane_test_pattern_gen_tb;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct {
    logic [127:0] d;
    logic [127:0] m;
    logic [1:0]   b;
  } exp_s;
  logic         core_clk = 1'b0;
  logic         nrst = 1'b0;
  logic [3:0]   test_pattern_select = 4'h0;
  logic [3:0]   link_mode_lanes = 4'h4;
  logic [1:0]   link_mode_nprime = 2'h0;
  logic [4:0]   frame_octets = 5'h01;
  logic [9:0]   multiframe_frames = 10'h001;
  logic         coding_64b66b = 1'b0;
  logic         link_enable = 1'b0;
  logic         ilas_done = 1'b1;
  logic         serdes_ready = 1'b1;
  logic [1:0]   stall_mode = 2'h0;
  logic [15:0]  lane_power;
  logic         test_active;
  logic [127:0] out_data;
  logic         out_bypass_link;
  logic         out_bypass_transport;
  logic         out_valid;
  logic         out_ready;
  logic         popped;
  logic [31:0]  hist [16];
  exp_s         q [$];
  int           fails = 0;
  int           checks_done = 0;
  int           cycles = 0;
  int           pops = 0;
  int           nbits = 0;
  int           prbs_a = 0;
  int           prbs_b = 0;

  serial_lane_test_pattern_gen serial_lane_test_pattern_gen_i (.*);
  lane_rx_model lane_rx_model_i (.core_clk(core_clk), .out_valid(out_valid),
    .stall_mode(stall_mode), .out_ready(out_ready), .popped(popped));

  always #50 core_clk = ~core_clk;
  ////////////////////////////////////////////////////////////////////////
  task automatic stop_test();
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  task automatic check(input logic ok, input string msg);
    checks_done++;
    if (ok !== 1'b1) begin
      fails++;
      $display("wrong value at %0t: %s", $time, msg);
    end
  endtask

  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 20000) begin
      check(1'b0, "run hung");
      stop_test();
    end
  end

  function automatic logic [3:0] nib(input int f8, input int i, input int n);
    if (f8 == 0) return 4'((4 * i + n) % 16);
    if (n == 15) return 4'h0;
    case (n % 3)
      0:       return 4'(15 - i);
      1:       return 4'(i);
      default: return 4'(n / 3 + 1);
    endcase
  endfunction
  ////////////////////////////////////////////////////////////////////////
  task automatic prbs_word();
    logic ok;
    logic b;
    ok = (out_bypass_link & out_bypass_transport);
    for (int l = 0; l < 16; l++) begin
      for (int k = 7; k >= 0; k--) begin
        b = out_data[8*l+k];
        if (nbits + 7 - k >= prbs_b)
          ok &= (b === (hist[l][prbs_a-1] ^ hist[l][prbs_b-1]));
        hist[l] = {hist[l][30:0], b};
      end
    end
    nbits += 8;
    check(ok, "prbs stream");
    if (nbits == 32)
      for (int l = 1; l < 16; l++)
        check(hist[l] !== hist[l-1], "lane phase");
  endtask

  // the watcher: in prbs runs a popped word is judged by the recurrence, else against the oldest note while one is queued
  always @(posedge core_clk) begin
    if (popped === 1'b1) begin
      pops++;
      if (prbs_b != 0) prbs_word();
      else if (q.size() > 0) begin
        check((out_data & q[0].m) === q[0].d, "lane octets");
        check({out_bypass_link, out_bypass_transport} === q[0].b,
              "bypass flags");
        void'(q.pop_front());
      end
    end
  end
  ////////////////////////////////////////////////////////////////////////
  // words left over from the last run are dropped: the queue is empty then
  task automatic start(input logic [3:0] s, input logic [1:0] np,
                       input logic [3:0] ln, input logic [4:0] f,
                       input logic [9:0] k, input int a, input int b);
    @(negedge core_clk);
    link_enable = 1'b0; // select only moves with the link down
    prbs_b = 0;
    stall_mode = 2'h0;
    repeat (4) @(negedge core_clk);
    q.delete();
    nbits = 0;
    prbs_a = a;
    prbs_b = b;
    test_pattern_select = s;
    link_mode_nprime = np;
    link_mode_lanes = ln;
    frame_octets = f;
    multiframe_frames = k;
    @(negedge core_clk);
    link_enable = 1'b1; // pattern restarts from its head
  endtask

  task automatic run_pat(input logic [3:0] s, input logic [1:0] np,
                         input logic [3:0] ln, input int f, input int k,
                         input int n);
    logic [127:0] d;
    logic [127:0] m;
    logic [1:0]   b;
    int           i;
    int           o;
    start(s, np, ln, 5'(f), 10'(k), 0, 0);
    stall_mode = 2'h1;
    b = (s == lane_test_pkg::SEL_CLOCK) ? 2'b11 : 2'b00;
    if (s == lane_test_pkg::SEL_RAMP) b = 2'b01;
    for (int c = 0; c < n; c++) begin
      o = 2 * (c % f);
      for (int l = 0; l < 16; l++) begin
        i = l % 8;
        m[8*l+:8] = (i < ln || s != lane_test_pkg::SEL_SHORT) ? 8'hff : 8'h00;
        if (s == lane_test_pkg::SEL_CLOCK)
          d[8*l+:8] = (c % 2 == 0) ? 8'hff : 8'h00;
        else if (s == lane_test_pkg::SEL_RAMP)
          d[8*l+:8] = 8'((c / f) % k);
        else if (np == lane_test_pkg::NP_8)
          d[8*l+:8] = ((c / f) % 2 == 1) ? 8'hff - 8'(i) : 8'(i);
        else
          d[8*l+:8] = {nib(f == 8, i, o), nib(f == 8, i, o + 1)};
      end
      q.push_back('{d & m, m, b});
    end
    // stall long enough to fill the buffer; no word may be lost
    stall_mode = 2'h2;
    repeat (10) @(negedge core_clk);
    check(out_valid === 1'b1, "buffer held");
    stall_mode = 2'h1;
    while (q.size() > 0) @(negedge core_clk);
  endtask

  task automatic silent();
    int p;
    p = pops;
    repeat (12) @(negedge core_clk);
    check(pops == p, "word while idle");
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial begin
    void'($urandom(32'h7ebeed92));
    repeat (10) @(negedge core_clk);
    nrst = 1'b1;
    #1;
    check(test_active === 1'b0 && lane_power === 16'h0f0f, "idle");
    link_mode_lanes = 4'h6;
    test_pattern_select = lane_test_pkg::SEL_RAMP;
    #1;
    check(test_active === 1'b1 && lane_power === 16'h3f3f, "power");
    run_pat(lane_test_pkg::SEL_CLOCK, lane_test_pkg::NP_8, 4'h8, 1, 1, 40);
    coding_64b66b = 1'b1;
    run_pat(lane_test_pkg::SEL_SHORT, lane_test_pkg::NP_8, 4'h4, 2, 1, 24);
    coding_64b66b = 1'b0;
    run_pat(lane_test_pkg::SEL_SHORT, lane_test_pkg::NP_12, 4'h6, 2, 1, 12);
    run_pat(lane_test_pkg::SEL_SHORT, lane_test_pkg::NP_12, 4'h8, 8, 1, 24);
    start(lane_test_pkg::SEL_SHORT, lane_test_pkg::NP_16, 4'h8, 5'h01, 10'h001, 0, 0);
    silent();
    ilas_done = 1'b0;
    start(lane_test_pkg::SEL_RAMP, lane_test_pkg::NP_8, 4'h8, 5'h01, 10'h005, 0, 0);
    silent();
    ilas_done = 1'b1;
    run_pat(lane_test_pkg::SEL_RAMP, lane_test_pkg::NP_8, 4'h2, 2, 5, 30);
    coding_64b66b = 1'b1;
    ilas_done = 1'b0;
    run_pat(lane_test_pkg::SEL_RAMP, lane_test_pkg::NP_12, 4'h8, 1, 300, 320);
    start(lane_test_pkg::SEL_PRBS7, lane_test_pkg::NP_8, 4'h8, 5'h01, 10'h001, 6, 7);
    stall_mode = 2'h1;
    while (nbits < 320) @(negedge core_clk);
    start(lane_test_pkg::SEL_PRBS9, lane_test_pkg::NP_8, 4'h8, 5'h01, 10'h001, 5, 9);
    while (nbits < 320) @(negedge core_clk);
    start(lane_test_pkg::SEL_PRBS15, lane_test_pkg::NP_8, 4'h8, 5'h01, 10'h001, 14, 15);
    while (nbits < 320) @(negedge core_clk);
    start(lane_test_pkg::SEL_PRBS23, lane_test_pkg::NP_8, 4'h8, 5'h01, 10'h001, 18, 23);
    while (nbits < 320) @(negedge core_clk);
    start(lane_test_pkg::SEL_PRBS31, lane_test_pkg::NP_8, 4'h8, 5'h01, 10'h001, 28, 31);
    while (nbits < 320) @(negedge core_clk);
    stop_test();
  end
endmodule
